// file: rtl/flash_seq_pkg.sv
// constants, types and encodings shared by the flash command sequencer
// assumes a 24-bit byte address space and a 100 MHz core clock
package flash_seq_pkg;

  // address space
  localparam int ADDR_W = 24;

  // opcodes seen on the command link
  localparam logic [7:0] OPC_QUAD_IO_READ     = 8'hEB;
  localparam logic [7:0] OPC_BURST_LENGTH     = 8'hC0;
  localparam logic [7:0] OPC_SECTOR_ERASE     = 8'h20;
  localparam logic [7:0] OPC_HALF_BLOCK_ERASE = 8'h52;
  localparam logic [7:0] OPC_WRITE_LATCH_SET  = 8'h06;

  // configuration register positions of the dummy-cycle select
  localparam int CFG_DUMMY_SEL_LOW_BIT  = 6;
  localparam int CFG_DUMMY_SEL_HIGH_BIT = 7;

  // dummy clocks per select code, indicator clocks included
  localparam logic [4:0] DUMMY_CLKS_SEL0 = 5'h06;
  localparam logic [4:0] DUMMY_CLKS_SEL1 = 5'h04;
  localparam logic [4:0] DUMMY_CLKS_SEL2 = 5'h08;
  localparam logic [4:0] DUMMY_CLKS_SEL3 = 5'h0A;

  // last-clock counts of each phase; ESCAPE_CLKS is a full clock count
  localparam logic [4:0] SPI_BYTE_LAST  = 5'h07;
  localparam logic [4:0] QPI_BYTE_LAST  = 5'h01;
  localparam logic [4:0] QUAD_ADDR_LAST = 5'h05;
  localparam logic [4:0] SPI_ADDR_LAST  = 5'h17;
  localparam logic [4:0] IND_LAST_CLK   = 5'h01;
  localparam logic [3:0] ESCAPE_CLKS    = 4'h8;

  // wrap code fields
  localparam int         WRAP_OFF_BIT   = 4;
  localparam logic [2:0] WRAP_HIGH_ZERO = 3'h0;

  // erase geometry and legacy protection
  localparam int         SECTOR_SHIFT     = 12;
  localparam int         HALF_BLOCK_SHIFT = 15;
  localparam int         BLOCK64_SHIFT    = 16;
  localparam logic [8:0] BLOCK64_COUNT    = 9'h100;
  localparam logic [3:0] BP_ALL_LEVEL     = 4'h9;

  // timing
  localparam int CLOCK_FREQ_MHZ           = 100;
  localparam int SECTOR_ERASE_TIME_US     = 30;
  localparam int HALF_BLOCK_ERASE_TIME_US = 150;

  typedef enum logic [2:0] {
    L_OPCODE = 3'b000,
    L_ADDR   = 3'b001,
    L_DUMMY  = 3'b010,
    L_DATA   = 3'b011,
    L_WRAP   = 3'b100,
    L_EADDR  = 3'b101,
    L_ARMED  = 3'b110,
    L_IGNORE = 3'b111
  } link_state_t;

  typedef enum logic [1:0] {
    C_IDLE  = 2'b00,
    C_CHECK = 2'b01,
    C_ERASE = 2'b10
  } core_state_t;

  typedef struct packed {
    logic              half;
    logic [ADDR_W-1:0] addr;
  } erase_cmd_t;

  typedef struct packed {
    logic       busy;
    logic       four_line;
    logic [1:0] dummy_sel;
  } core_status_t;

  typedef struct packed {
    logic cs_n;
    logic arm;
    logic wel_tgl;
  } link_flags_t;

endpackage

// file: rtl/level_sync.sv
// two-flop synchroniser for slowly changing levels
// assumes each bit is a level that holds for several destination clocks
`timescale 1ns/1ns
module level_sync #(
  parameter int W = 1
) (
  input  wire logic         clock_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clock_i) begin
    meta_q <= d_i;
    q_o    <= meta_q;
  end

endmodule

// file: rtl/quad_read_wrap_xip_erase.sv
// quad i/o read, wrap burst, execute-in-place and 4K/32K erase sequencer
// assumes sclk_i stands still outside frames; the array answers array_data_i
// combinationally for array_addr_o and erases on erase_req_o
`timescale 1ns/1ns

// What this block does
// RULE1 - quad read: address, dummy, 4-bit data
// RULE2 - sample rising edge, drive falling edge
// RULE3 - read address increments, rolls to zero
// RULE4 - single-line opcode, quad address, dummies, data
// RULE5 - four-line opcode form accepted too
// RULE6 - quad read ignored while busy
// RULE7 - dummy count from config bits 6,7
// RULE8 - wrapping off after reset
// RULE9 - host sends C0h plus wrap code
// RULE10 - wrap codes 8/16/32/64, 1xh off
// RULE11 - wrap within aligned window
// RULE12 - wrap setting held, replaceable anytime
// RULE13 - wrap applies to EBh both modes
// RULE14 - opcode 8 single or 2 quad clocks
// RULE15 - complementary indicator enters enhance mode
// RULE16 - other indicator leaves after next frame; the code clears enhance at that indicator, so the next frame needs the opcode
// RULE17 - enhance mode: frame starts with address
// RULE18 - eight all-ones clocks force enhance exit
// RULE19 - enhance only via quad i/o read
// RULE20 - sector erase: 4K, needs latch, A12+
// RULE21 - erase discarded unless select ends exactly
// RULE22 - erase starts at rise, flags busy
// RULE23 - protected target skips erase
// RULE24 - 32K erase, any address, needs latch
// RULE25 - erase without latch is ignored
module quad_read_wrap_xip_erase #(
  parameter int unsigned SECTOR_ERASE_CYCLES =
    flash_seq_pkg::SECTOR_ERASE_TIME_US * flash_seq_pkg::CLOCK_FREQ_MHZ,
  parameter int unsigned HALF_BLOCK_ERASE_CYCLES =
    flash_seq_pkg::HALF_BLOCK_ERASE_TIME_US * flash_seq_pkg::CLOCK_FREQ_MHZ
) (
  input  wire logic                             clock_i,
  input  wire logic                             rst_n_i,
  input  wire logic                             sclk_i,
  input  wire logic                             cs_n_i,
  input  wire logic [3:0]                       sio_i,
  output logic      [3:0]                       sio_o,
  output logic      [3:0]                       sio_oe_o,
  input  wire logic                             four_line_command_mode_i,
  input  wire logic [7:0]                       config_reg_i,
  input  wire logic                             protection_scheme_sel_i,
  input  wire logic [3:0]                       block_protect_bits_i,
  input  wire logic                             sector_lock_bits_i,
  input  wire logic                             other_busy_i,
  input  wire logic [7:0]                       array_data_i,
  output logic      [flash_seq_pkg::ADDR_W-1:0] array_addr_o,
  output logic      [flash_seq_pkg::ADDR_W-1:0] lookup_addr_o,
  output logic                                  erase_req_o,
  output logic                                  erase_half_o,
  output logic      [flash_seq_pkg::ADDR_W-1:0] erase_addr_o,
  output logic                                  write_in_progress_o,
  output logic                                  write_enable_latch_o,
  output logic                                  execute_in_place_o
);
  import flash_seq_pkg::*;

  // wrap window mask per code
  function automatic logic [5:0] wrap_mask(input logic [1:0] code);
    unique case (code)
      2'h0: wrap_mask = 6'h07;
      2'h1: wrap_mask = 6'h0F;
      2'h2: wrap_mask = 6'h1F;
      2'h3: wrap_mask = 6'h3F;
    endcase
  endfunction

  // next read address, plain roll-over or inside the wrap window
  function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a,
                                                  input logic en,
                                                  input logic [1:0] code);
    logic [ADDR_W-1:0] mask;
    logic [ADDR_W-1:0] inc;
    mask = {{(ADDR_W-6){1'b0}}, wrap_mask(code)};
    inc  = a + 24'h000001;
    next_addr = en ? ((a & ~mask) | (inc & mask)) : inc;
  endfunction

  // last dummy clock count per select code, one less than its dummy clocks
  function automatic logic [4:0] dummy_last(input logic [1:0] sel);
    logic [4:0] n;
    unique case (sel)
      2'h0: n = DUMMY_CLKS_SEL0;
      2'h1: n = DUMMY_CLKS_SEL1;
      2'h2: n = DUMMY_CLKS_SEL2;
      2'h3: n = DUMMY_CLKS_SEL3;
    endcase
    dummy_last = n - 5'h01;
  endfunction

  // legacy protection: protected area grows down from the top block
  function automatic logic bp_protects(input logic [3:0] bp,
                                       input logic [ADDR_W-1:0] a);
    logic [8:0] cnt;
    cnt = 9'h001 << (bp - 4'h1);
    if (bp == 4'h0) bp_protects = 1'b0;
    else if (bp >= BP_ALL_LEVEL) bp_protects = 1'b1;
    else bp_protects = {1'b0, a[ADDR_W-1:BLOCK64_SHIFT]} >= (BLOCK64_COUNT - cnt);
  endfunction

  // link side: frame state cleared by chip select high
  logic              frame_rst;
  link_state_t       st_q, st_d;
  logic [4:0]        cnt_q, cnt_d;
  logic [23:0]       sh_q, sh_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic              nib_q, nib_d;
  logic              half_q, half_d;
  logic [3:0]        run_q, run_d;
  logic              ones_q, ones_d;
  // link side: state kept across frames
  logic              xip_q, xip_d;
  logic              wrap_en_q, wrap_en_d;
  logic [1:0]        wrap_code_q, wrap_code_d;
  logic              arm_q, arm_d;
  erase_cmd_t        ecmd_q, ecmd_d;
  logic              wel_tgl_q, wel_tgl_d;
  // requests from frame logic to persistent logic
  logic              xip_set, xip_clr, wrap_load, arm_set, arm_clr, wel_req;
  logic [7:0]        wrap_byte;
  // link side outputs
  logic [3:0]        sio_d, sio_oe_d;
  core_status_t      stat_link;
  logic              quad_cmd, cmd_done, line_one;
  logic [23:0]       sh_cmd;

  assign frame_rst = cs_n_i | ~rst_n_i;
  assign quad_cmd  = stat_link.four_line;
  assign sh_cmd    = quad_cmd ? {sh_q[19:0], sio_i} : {sh_q[22:0], sio_i[0]};
  assign cmd_done  = cnt_q == (quad_cmd ? QPI_BYTE_LAST : SPI_BYTE_LAST);
  assign line_one  = quad_cmd ? (&sio_i) : sio_i[0];

  // frame sequencing on rising sclk
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + 5'h01;
    sh_d = sh_q;
    addr_d = addr_q;
    nib_d = nib_q;
    half_d = half_q;
    run_d = (run_q == ESCAPE_CLKS) ? run_q : run_q + 4'h1;
    ones_d = ones_q & line_one;
    xip_set = 1'b0;
    xip_clr = 1'b0;
    wrap_load = 1'b0;
    arm_set = 1'b0;
    arm_clr = 1'b0;
    wel_req = 1'b0;
    wrap_byte = sh_cmd[7:0];
    unique case (st_q)
      L_OPCODE: begin
        // first edge of a frame withdraws any pending erase arm
        if (cnt_q == 5'h00) arm_clr = 1'b1;
        // RULE17 enhance frame skips opcode
        if (cnt_q == 5'h00 && xip_q) begin
          sh_d = {sh_q[19:0], sio_i};
          st_d = stat_link.busy ? L_IGNORE : L_ADDR;
        end else begin
          // RULE14 eight or two opcode clocks
          sh_d = sh_cmd;
          if (cmd_done) begin
            cnt_d = 5'h00;
            st_d = L_IGNORE;
            unique case (sh_cmd[7:0])
              // RULE4 RULE5 RULE6 read opcode accepted
              OPC_QUAD_IO_READ: if (!stat_link.busy) st_d = L_ADDR;
              OPC_BURST_LENGTH: st_d = L_WRAP;
              OPC_SECTOR_ERASE, OPC_HALF_BLOCK_ERASE: begin
                half_d = sh_cmd[7:0] == OPC_HALF_BLOCK_ERASE;
                if (!stat_link.busy) st_d = L_EADDR;
              end
              OPC_WRITE_LATCH_SET: wel_req = 1'b1;
              default: st_d = L_IGNORE;
            endcase
          end
        end
      end
      L_ADDR: begin
        // RULE1 RULE2 address nibbles on rising edge
        sh_d = {sh_q[19:0], sio_i};
        if (cnt_q == QUAD_ADDR_LAST) begin
          addr_d = {sh_q[19:0], sio_i};
          cnt_d = 5'h00;
          st_d = L_DUMMY;
        end
      end
      L_DUMMY: begin
        sh_d = {sh_q[19:0], sio_i};
        // RULE15 RULE16 RULE19 indicator decides enhance
        if (cnt_q == IND_LAST_CLK) begin
          if (sh_q[3:0] == ~sio_i) xip_set = 1'b1;
          else xip_clr = 1'b1;
        end
        // RULE7 dummy length from config
        if (cnt_q == dummy_last(stat_link.dummy_sel)) begin
          cnt_d = 5'h00;
          nib_d = 1'b0;
          st_d = L_DATA;
        end
      end
      L_DATA: begin
        nib_d = ~nib_q;
        // RULE3 RULE11 RULE13 advance after each byte
        if (nib_q) addr_d = next_addr(addr_q, wrap_en_q, wrap_code_q);
      end
      L_WRAP: begin
        sh_d = sh_cmd;
        if (cmd_done) begin
          wrap_load = 1'b1;
          st_d = L_IGNORE;
        end
      end
      L_EADDR: begin
        sh_d = sh_cmd;
        // RULE20 RULE24 address complete, arm erase
        if (cnt_q == (quad_cmd ? QUAD_ADDR_LAST : SPI_ADDR_LAST)) begin
          arm_set = 1'b1;
          st_d = L_ARMED;
        end
      end
      L_ARMED: begin
        // RULE21 any further clock discards erase
        arm_clr = 1'b1;
        st_d = L_IGNORE;
      end
      L_IGNORE: cnt_d = cnt_q;
    endcase
    // RULE18 eight all-ones clocks leave enhance
    if (xip_q && ones_d && run_q == ESCAPE_CLKS - 4'h1) begin
      xip_clr = 1'b1;
      xip_set = 1'b0;
      st_d = L_IGNORE;
    end
  end

  always_ff @(posedge sclk_i or posedge frame_rst) begin
    if (frame_rst) begin
      st_q   <= L_OPCODE;
      cnt_q  <= 5'h00;
      sh_q   <= 24'h000000;
      addr_q <= 24'h000000;
      nib_q  <= 1'b0;
      half_q <= 1'b0;
      run_q  <= 4'h0;
      ones_q <= 1'b1;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      addr_q <= addr_d;
      nib_q  <= nib_d;
      half_q <= half_d;
      run_q  <= run_d;
      ones_q <= ones_d;
    end
  end

  // state that survives chip select
  always_comb begin
    xip_d = xip_q;
    wrap_en_d = wrap_en_q;
    wrap_code_d = wrap_code_q;
    arm_d = arm_q;
    ecmd_d = ecmd_q;
    wel_tgl_d = wel_tgl_q ^ wel_req;
    if (xip_set) xip_d = 1'b1;
    if (xip_clr) xip_d = 1'b0;
    // RULE10 RULE12 decode and replace wrap setting
    if (wrap_load) begin
      if (wrap_byte[WRAP_OFF_BIT]) begin
        wrap_en_d = 1'b0;
      end else if (wrap_byte[7:5] == WRAP_HIGH_ZERO && wrap_byte[3:2] == 2'h0) begin
        wrap_en_d = 1'b1;
        wrap_code_d = wrap_byte[1:0];
      end
    end
    if (arm_clr) arm_d = 1'b0;
    if (arm_set) begin
      arm_d = 1'b1;
      ecmd_d.half = half_q;
      ecmd_d.addr = sh_cmd;
    end
  end

  // RULE8 wrapping off from reset
  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      xip_q       <= 1'b0;
      wrap_en_q   <= 1'b0;
      wrap_code_q <= 2'h0;
      arm_q       <= 1'b0;
      ecmd_q      <= '0;
      wel_tgl_q   <= 1'b0;
    end else begin
      xip_q       <= xip_d;
      wrap_en_q   <= wrap_en_d;
      wrap_code_q <= wrap_code_d;
      arm_q       <= arm_d;
      ecmd_q      <= ecmd_d;
      wel_tgl_q   <= wel_tgl_d;
    end
  end

  // RULE1 RULE2 data nibbles driven on falling edge
  always_comb begin
    sio_d    = 4'h0;
    sio_oe_d = 4'h0;
    if (st_q == L_DATA) begin
      sio_oe_d = 4'hF;
      sio_d = nib_q ? array_data_i[3:0] : array_data_i[7:4];
    end
  end

  always_ff @(negedge sclk_i or posedge frame_rst) begin
    if (frame_rst) begin
      sio_o    <= 4'h0;
      sio_oe_o <= 4'h0;
    end else begin
      sio_o    <= sio_d;
      sio_oe_o <= sio_oe_d;
    end
  end

  assign array_addr_o       = addr_q;
  assign execute_in_place_o = xip_q;

  // core side
  core_status_t      stat_q, stat_d;
  link_flags_t       flags_s;
  core_state_t       cst_q, cst_d;
  logic              cs_prev_q, tgl_prev_q;
  logic              wel_q, wel_d, wip_q, wip_d, req_q, req_d;
  logic [31:0]       timer_q, timer_d;
  erase_cmd_t        tgt_q, tgt_d;
  logic              protected_hit;

  // status into the link, link flags into the core
  level_sync #(.W(4)) u_to_link (
    .clock_i (sclk_i),
    .d_i     (stat_q),
    .q_o     (stat_link)
  );

  level_sync #(.W(3)) u_to_core (
    .clock_i (clock_i),
    .d_i     ({cs_n_i, arm_q, wel_tgl_q}),
    .q_o     (flags_s)
  );

  assign protected_hit = protection_scheme_sel_i ? sector_lock_bits_i
                       : bp_protects(block_protect_bits_i, tgt_q.addr);

  // erase control and latch
  always_comb begin
    cst_d = cst_q;
    wel_d = wel_q;
    wip_d = wip_q;
    req_d = 1'b0;
    tgt_d = tgt_q;
    timer_d = timer_q;
    stat_d.busy = wip_q | other_busy_i;
    stat_d.four_line = four_line_command_mode_i;
    stat_d.dummy_sel = {config_reg_i[CFG_DUMMY_SEL_HIGH_BIT],
                        config_reg_i[CFG_DUMMY_SEL_LOW_BIT]};
    unique case (cst_q)
      C_IDLE: begin
        // RULE22 RULE25 start only at select rise with latch set
        if (flags_s.cs_n && !cs_prev_q && flags_s.arm && wel_q) begin
          tgt_d.half = ecmd_q.half;
          tgt_d.addr = ecmd_q.half
                     ? {ecmd_q.addr[ADDR_W-1:HALF_BLOCK_SHIFT], {HALF_BLOCK_SHIFT{1'b0}}}
                     : {ecmd_q.addr[ADDR_W-1:SECTOR_SHIFT], {SECTOR_SHIFT{1'b0}}};
          cst_d = C_CHECK;
        end
      end
      C_CHECK: begin
        // RULE23 protected target skipped
        if (protected_hit) begin
          cst_d = C_IDLE;
        end else begin
          req_d = 1'b1;
          wip_d = 1'b1;
          timer_d = tgt_q.half ? 32'(HALF_BLOCK_ERASE_CYCLES - 1)
                               : 32'(SECTOR_ERASE_CYCLES - 1);
          cst_d = C_ERASE;
        end
      end
      C_ERASE: begin
        timer_d = timer_q - 32'h00000001;
        // RULE22 finish clears busy and latch
        if (timer_q == 32'h00000000) begin
          wip_d = 1'b0;
          wel_d = 1'b0;
          cst_d = C_IDLE;
        end
      end
      default: cst_d = C_IDLE;
    endcase
    // latch set beats the end-of-erase clear
    if (flags_s.wel_tgl != tgl_prev_q) wel_d = 1'b1;
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cst_q      <= C_IDLE;
      cs_prev_q  <= 1'b1;
      tgl_prev_q <= 1'b0;
      wel_q      <= 1'b0;
      wip_q      <= 1'b0;
      req_q      <= 1'b0;
      timer_q    <= 32'h00000000;
      tgt_q      <= '0;
      stat_q     <= '0;
    end else begin
      cst_q      <= cst_d;
      cs_prev_q  <= flags_s.cs_n;
      tgl_prev_q <= flags_s.wel_tgl;
      wel_q      <= wel_d;
      wip_q      <= wip_d;
      req_q      <= req_d;
      timer_q    <= timer_d;
      tgt_q      <= tgt_d;
      stat_q     <= stat_d;
    end
  end

  assign lookup_addr_o        = tgt_q.addr;
  assign erase_addr_o         = tgt_q.addr;
  assign erase_half_o         = tgt_q.half;
  assign erase_req_o          = req_q;
  assign write_in_progress_o  = wip_q;
  assign write_enable_latch_o = wel_q;

endmodule

// file: tb/flash_seq_sva.sv
// assertions on the core side of the flash sequencer: erase start, line drive
// assumes it is bound to quad_read_wrap_xip_erase and sees its ports only
`timescale 1ns/1ns
module flash_seq_sva (
  input wire logic                             clock_i,
  input wire logic                             rst_n_i,
  input wire logic                             cs_n_i,
  input wire logic [3:0]                       sio_oe_o,
  input wire logic                             erase_req_o,
  input wire logic                             erase_half_o,
  input wire logic [flash_seq_pkg::ADDR_W-1:0] erase_addr_o,
  input wire logic                             write_in_progress_o,
  input wire logic                             write_enable_latch_o
);
  import flash_seq_pkg::*;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // an erase start is one pulse, then a busy stretch
  sequence start_s;
    erase_req_o ##1 !erase_req_o;
  endsequence
  sequence busy_s;
    write_in_progress_o [*8];
  endsequence
  a_oe_deselect: assert property (cs_n_i [*2] |-> sio_oe_o == 4'h0)
    else $error("lines driven while deselected");
  a_oe_all_four: assert property (sio_oe_o != 4'h0 |-> sio_oe_o == 4'hF)
    else $error("partial nibble drive");
  a_start_pulse: assert property (erase_req_o |-> start_s)
    else $error("erase start longer than one cycle");
  a_busy_after: assert property (erase_req_o |=> busy_s)
    else $error("busy flag missing after erase start");
  a_start_latch: assert property (erase_req_o |-> write_enable_latch_o)
    else $error("erase started without write latch");
  a_start_outside: assert property (erase_req_o |-> cs_n_i && $past(cs_n_i))
    else $error("erase started inside a frame");
  a_sector_base: assert property (erase_req_o && !erase_half_o |-> erase_addr_o[11:0] == 12'h000)
    else $error("sector target not aligned");
  a_half_base: assert property (erase_req_o && erase_half_o |-> erase_addr_o[14:0] == 15'h0000)
    else $error("half block target not aligned");
  a_done_clears: assert property ($fell(write_in_progress_o) |-> !write_enable_latch_o)
    else $error("write latch kept after erase end");
endmodule
bind quad_read_wrap_xip_erase flash_seq_sva chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .sio_oe_o(sio_oe_o),
  .erase_req_o(erase_req_o), .erase_half_o(erase_half_o), .erase_addr_o(erase_addr_o),
  .write_in_progress_o(write_in_progress_o), .write_enable_latch_o(write_enable_latch_o));

// file: tb/link_host.sv
// behavioural host controller on the serial/quad command link
// assumes the bench calls one frame at a time; clock stands still between frames
`timescale 1ns/1ns
module link_host (
  output logic            sclk_o,
  output logic            cs_n_o,
  output logic      [3:0] sio_o,
  input  wire logic [3:0] sio_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sio_o  = 4'h5;
  end
  // select falls before the first clock
  task automatic open_frame();
    cs_n_o = 1'b0;
    #6;
  endtask
  // one 15 ns link clock, lines sampled at the rise
  task automatic pulse(output logic [3:0] seen);
    #7;
    seen = sio_i;
    sclk_o = 1'b1;
    #8;
    sclk_o = 1'b0;
  endtask
  // msb first; spare lines toggle since they are don't care
  task automatic send(input logic [31:0] v, input int n, input logic quad);
    logic [3:0] s;
    for (int i = n - 1; i >= 0; i--) begin
      sio_o = quad ? v[4*i+:4] : {~sio_o[3:1], v[i]};
      pulse(s);
    end
  endtask
  // high nibble first
  task automatic get_byte(output logic [7:0] b);
    pulse(b[7:4]);
    pulse(b[3:0]);
  endtask
  // select rises right after the last unit; released lines invert
  task automatic close_frame();
    #6;
    cs_n_o = 1'b1;
    sio_o = ~sio_o;
    #90;
  endtask
endmodule

// file: tb/quad_read_wrap_xip_erase_test.sv
// self-checking bench for quad read, wrap burst, enhance mode and erase
// assumes link_host as far side and a behavioural array answering reads
`timescale 1ns/1ns
module quad_read_wrap_xip_erase_test;
  import flash_seq_pkg::*;
  logic        clock_i, rst_n_i, quad, prot_sel, lock_on, other_busy;
  logic        sclk, cs_n, req, half, write_in_progress, write_enable_latch, xip, got_half;
  logic [7:0]  cfg;
  logic [3:0]  bp, host_sio, dut_sio, dut_oe;
  wire  [3:0]  line;
  logic [23:0] rd_addr, lk_addr, er_addr, got_addr;
  int          error_cnt, total_checks, reqs, oe_hits;
  // array content, distinct across byte and page boundaries
  function automatic logic [7:0] mem(input logic [23:0] a);
    return a[7:0] + a[15:8] + a[23:16] + 8'h3C;
  endfunction
  // the device wins every line it enables, the host drives the rest
  assign line = (dut_oe & dut_sio) | (~dut_oe & host_sio);
  link_host h (.sclk_o(sclk), .cs_n_o(cs_n), .sio_o(host_sio), .sio_i(line));
  quad_read_wrap_xip_erase #(.SECTOR_ERASE_CYCLES(20), .HALF_BLOCK_ERASE_CYCLES(40)) dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n), .sio_i(line),
    .sio_o(dut_sio), .sio_oe_o(dut_oe), .four_line_command_mode_i(quad),
    .config_reg_i(cfg), .protection_scheme_sel_i(prot_sel), .block_protect_bits_i(bp),
    .sector_lock_bits_i(lock_on && lk_addr[23:12] == 12'h345), .other_busy_i(other_busy),
    .array_data_i(mem(rd_addr)), .array_addr_o(rd_addr), .lookup_addr_o(lk_addr),
    .erase_req_o(req), .erase_half_o(half), .erase_addr_o(er_addr),
    .write_in_progress_o(write_in_progress), .write_enable_latch_o(write_enable_latch), .execute_in_place_o(xip));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // erase starts and line drives seen so far
  always @(posedge clock_i) begin
    if (req === 1'b1) begin
      reqs++;
      got_addr = er_addr;
      got_half = half;
    end
  end
  always @(posedge sclk) if (|dut_oe) oe_hits++;
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic op(input logic [7:0] c);
    h.send({24'h0, c}, quad ? 2 : 8, quad);
  endtask
  // status reaches link logic only on link clocks
  task automatic prime();
    h.open_frame();
    h.send(32'h0, 2, 1'b1);
    h.close_frame();
  endtask
  task automatic setup(input logic q, input logic [7:0] c);
    @(posedge clock_i);
    quad <= q;
    cfg  <= c;
    repeat (4) @(posedge clock_i);
    prime();
  endtask
  // read n bytes; m marks the address bits that advance
  task automatic rd(input logic [23:0] a, input logic [7:0] p, input logic skip,
                    input logic [23:0] m, input int n);
    logic [7:0] b;
    logic [4:0] d;
    d = cfg[7:6] == 2'h0 ? DUMMY_CLKS_SEL0 : cfg[7:6] == 2'h1 ? DUMMY_CLKS_SEL1 :
        cfg[7:6] == 2'h2 ? DUMMY_CLKS_SEL2 : DUMMY_CLKS_SEL3;
    h.open_frame();
    if (!skip) op(OPC_QUAD_IO_READ);
    h.send({8'h00, a}, 6, 1'b1);
    h.send({24'h0, p}, 2, 1'b1);
    h.send(32'h0, int'(d) - 2, 1'b1);
    for (int k = 0; k < n; k++) begin
      h.get_byte(b);
      check(b, mem((a & ~m) | ((a + k[23:0]) & m)), "read byte");
    end
    h.close_frame();
  endtask
  task automatic busy_rd();
    int         o0;
    logic [7:0] b;
    prime();
    o0 = oe_hits;
    h.open_frame();
    op(OPC_QUAD_IO_READ);
    h.send(32'h0, 10, 1'b1);
    h.get_byte(b);
    h.close_frame();
    check(oe_hits - o0, 0, "busy read drive");
  endtask
  task automatic er(input logic [7:0] c, input logic [23:0] a, input logic latch,
                    input logic extra, input logic ok, input logic [23:0] base);
    int r0;
    int i;
    r0 = reqs;
    if (latch) begin
      h.open_frame();
      op(OPC_WRITE_LATCH_SET);
      h.close_frame();
      check(write_enable_latch, 1'b1, "latch set");
    end
    h.open_frame();
    op(c);
    h.send({8'h00, a}, quad ? 6 : 24, quad);
    if (extra) h.send(32'h0, 1, quad);
    h.close_frame();
    check(reqs - r0, ok, "erase start");
    if (ok) begin
      check({got_half, got_addr}, {c == OPC_HALF_BLOCK_ERASE, base}, "target");
      check(write_in_progress, 1'b1, "busy");
      if (c == OPC_HALF_BLOCK_ERASE) busy_rd();
      for (i = 0; i < 100 && write_in_progress !== 1'b0; i++) @(posedge clock_i);
      if (i == 100) begin
        error_cnt++;
        close_out();
      end
    end
    check(write_enable_latch, !ok && latch, "latch after");
  endtask
  task automatic t_read();
    rd(24'hFFFFFE, 8'hFF, 1'b0, 24'hFFFFFF, 3);
    check(xip, 1'b0, "no enhance");
  endtask
  task automatic t_modes();
    for (int s = 0; s < 8; s++) begin
      setup(s[0], {s[2:1], 6'h00});
      rd(24'h000300, 8'hAA, 1'b0, 24'hFFFFFF, 2);
    end
  endtask
  task automatic t_wrap();
    for (int c = 0; c < 4; c++) begin
      setup(c[0], 8'h00);
      h.open_frame();
      op(OPC_BURST_LENGTH);
      op(c[7:0]);
      h.close_frame();
      rd(24'h000FFE + (24'h8 << c), 8'hFF, 1'b0, (24'h8 << c) - 1, 4);
    end
    h.open_frame();
    op(OPC_BURST_LENGTH);
    op(8'h10);
    h.close_frame();
    rd(24'h001006, 8'hFF, 1'b0, 24'hFFFFFF, 3);
  endtask
  task automatic t_xip();
    for (int q = 0; q < 2; q++) begin
      setup(q[0], 8'h00);
      rd(24'h000040, 8'hA5, 1'b0, 24'hFFFFFF, 1);
      check(xip, 1'b1, "enhance on");
      rd(24'h000080, 8'h5A, 1'b1, 24'hFFFFFF, 1);
      rd(24'h0000C0, 8'hFF, 1'b1, 24'hFFFFFF, 1);
      rd(24'h000100, 8'h00, 1'b0, 24'hFFFFFF, 1);
      check(xip, 1'b0, "enhance left");
      rd(24'h000140, 8'h0F, 1'b0, 24'hFFFFFF, 1);
      h.open_frame();
      h.send(32'hFFFFFFFF, 8, 1'b1);
      h.close_frame();
      check(xip, 1'b0, "enhance escape");
      rd(24'h000180, 8'h55, 1'b0, 24'hFFFFFF, 1);
    end
  endtask
  task automatic t_erase();
    setup(1'b0, 8'h00);
    er(OPC_SECTOR_ERASE, 24'h123456, 1'b1, 1'b0, 1'b1, 24'h123000);
    er(OPC_SECTOR_ERASE, 24'h123456, 1'b0, 1'b0, 1'b0, 24'h0);
    er(OPC_HALF_BLOCK_ERASE, 24'h12F456, 1'b1, 1'b0, 1'b1, 24'h128000);
    setup(1'b1, 8'h00);
    er(OPC_SECTOR_ERASE, 24'h123456, 1'b1, 1'b1, 1'b0, 24'h0);
    @(posedge clock_i);
    prot_sel <= 1'b1;
    lock_on  <= 1'b1;
    er(OPC_SECTOR_ERASE, 24'h345678, 1'b1, 1'b0, 1'b0, 24'h0);
    er(OPC_SECTOR_ERASE, 24'h346001, 1'b1, 1'b0, 1'b1, 24'h346000);
    @(posedge clock_i);
    prot_sel <= 1'b0;
    bp       <= BP_ALL_LEVEL;
    er(OPC_HALF_BLOCK_ERASE, 24'h000100, 1'b1, 1'b0, 1'b0, 24'h0);
    @(posedge clock_i);
    other_busy <= 1'b1;
    repeat (4) @(posedge clock_i);
    busy_rd();
  endtask
  initial begin
    {rst_n_i, quad, prot_sel, lock_on, other_busy} = 5'h00;
    cfg = 8'h00;
    bp = 4'h0;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    prime();
    t_read();
    t_modes();
    t_wrap();
    t_xip();
    t_erase();
    close_out();
  end
  // hang guard
  initial begin
    repeat (60000) @(posedge clock_i);
    error_cnt++;
    close_out();
  end
endmodule
